// ### core/spmux_pin_arb.v
`timescale 1ns/1ps
`include "spmux_consts.vh"

// ==================================================
// One pin: up to three alternate functions above the port bit
module spmux_pin_arb (
   input wire clk,
   input wire rstSync_n,
   input wire enFirst,
   input wire enSecond,
   input wire enThird,
   input wire firstOe,
   input wire firstOut,
   input wire secondOe,
   input wire secondOut,
   input wire thirdOe,
   input wire thirdOut,
   input wire portDir,
   input wire portOut,
   output reg [2:0] owner,
   output reg pinOe,
   output reg pinOut
);
   reg released_q;
   reg [2:0] owner_d;
   reg oe_d;
   reg out_d;

   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         released_q <= `SPMUX_RST_OWNED;
      end else begin
         released_q <= 1'b1;
      end
   end

   always @* begin
      owner_d = `SPMUX_OWN_PORT;
      oe_d = portDir;
      out_d = portOut;
      if (enFirst) begin
         owner_d = `SPMUX_OWN_FIRST;
         oe_d = firstOe;
         out_d = firstOut;
      end else if (enSecond) begin
         owner_d = `SPMUX_OWN_SECOND;
         oe_d = secondOe;
         out_d = secondOut;
      end else if (enThird) begin
         owner_d = `SPMUX_OWN_THIRD;
         oe_d = thirdOe;
         out_d = thirdOut;
      end
   end

   // Registered drive; first cycle after reset release still input
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         owner <= `SPMUX_OWN_PORT;
         pinOe <= 1'b0;
         pinOut <= 1'b0;
      end else if (!released_q) begin
         owner <= `SPMUX_OWN_PORT;
         pinOe <= 1'b0;
         pinOut <= 1'b0;
      end else begin
         owner <= owner_d;
         pinOe <= oe_d;
         pinOut <= out_d;
      end
   end
endmodule

// ### core/spmux_top.v
`timescale 1ns/1ps
`include "spmux_consts.vh"

// Functional notes
// - After reset every shared pin is a port input, whatever is enabled.
// - Several enabled functions: the highest-ranked one owns the pin.
// - Port A bit 0: analog 0, timer channel 0, key irq 0, port.
// - Port A bit 1: analog 1, timer channel 1, key irq 1, port.
// - Port A bit 2: interrupt input, timer ext clock, key irq 2, input port.
// - Port A bit 3: reset input, key irq 3, port.
// - Port A bit 4: oscillator output, analog 2, key irq 4, port.
// - Port A bit 5: oscillator input, analog 3, key irq 5, port.
// - Port B bits 0-3: analog 4-7, then sync serial functions, then port.
// - Port B bits 4-5: analog 8-9, then async receive/transmit, then port.
// - Analog selection never cuts off another enabled module's pin input.
module spmux_top (
   input wire clk,
   input wire rst_n,
   // Pins, split into in/out/oe
   input wire [5:0] portaPinIn,
   output wire [5:0] portaPinOut,
   output wire [5:0] portaPinOe,
   input wire [7:0] portbPinIn,
   output wire [7:0] portbPinOut,
   output wire [7:0] portbPinOe,
   // Port data/direction from the port logic
   input wire [5:0] portaDir,
   input wire [5:0] portaOut,
   input wire [7:0] portbDir,
   input wire [7:0] portbOut,
   output reg [5:0] portaIn,
   output reg [7:0] portbIn,
   // Analog
   input wire [9:0] analogEn,
   output reg [9:0] analogIn,
   // Timer
   input wire [3:0] timerChanEn,
   input wire [3:0] timerChanOe,
   input wire [3:0] timerChanOut,
   output reg [3:0] timerChanIn,
   input wire timerExtClockEn,
   output reg timerExtClock,
   // Keyboard
   input wire [5:0] keyIrqEn,
   output reg [5:0] keyIrqIn,
   // Interrupt, reset, oscillator
   input wire extIrqEn,
   output reg extIrqIn,
   input wire extResetEn,
   output reg extReset_n,
   input wire oscOutputEn,
   input wire oscOutputVal,
   input wire oscInputEn,
   output reg oscInput,
   // Synchronous serial: clock, data out, data in, select
   input wire [3:0] syncSerialEn,
   input wire [3:0] syncSerialOe,
   input wire [3:0] syncSerialOut,
   output reg [3:0] syncSerialIn,
   // Asynchronous serial
   input wire asyncSerialEn,
   input wire asyncTxOut,
   output reg asyncRxIn,
   // Owner code per pin
   output wire [17:0] portaOwner,
   output wire [23:0] portbOwner
);
   // ==================================================
   // Reset synchroniser
   reg rstMeta_q;
   reg rstSync_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // ==================================================
   // Pin input synchronisers
   reg [5:0] paMeta_q;
   reg [5:0] paSync_q;
   reg [7:0] pbMeta_q;
   reg [7:0] pbSync_q;
   always @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         paMeta_q <= 6'h00;
         paSync_q <= 6'h00;
         pbMeta_q <= 8'h00;
         pbSync_q <= 8'h00;
      end else begin
         paMeta_q <= portaPinIn;
         paSync_q <= paMeta_q;
         pbMeta_q <= portbPinIn;
         pbSync_q <= pbMeta_q;
      end
   end

   // ==================================================
   // Per-pin enables and drives in priority order
   wire [5:0] aFirst;
   wire [5:0] aSecond;
   wire [5:0] aThird;
   wire [5:0] aFirstOe;
   wire [5:0] aFirstOut;
   wire [5:0] aSecondOe;
   wire [5:0] aSecondOut;
   wire [7:0] bFirst;
   wire [7:0] bSecond;
   wire [7:0] bSecondOe;
   wire [7:0] bSecondOut;
   wire [5:0] aDirEff;

   assign aFirst = {oscInputEn, oscOutputEn, extResetEn, extIrqEn,
      analogEn[1], analogEn[0]};
   assign aSecond = {analogEn[3], analogEn[2], keyIrqEn[3], timerExtClockEn,
      timerChanEn[1], timerChanEn[0]};
   assign aThird = {keyIrqEn[5], keyIrqEn[4], 1'b0, keyIrqEn[2],
      keyIrqEn[1], keyIrqEn[0]};
   // On port A only timer channels and the oscillator output ever drive
   assign aFirstOe = {1'b0, 1'b1, 4'h0};
   assign aFirstOut = {1'b0, oscOutputVal, 4'h0};
   assign aSecondOe = {4'h0, timerChanOe[1], timerChanOe[0]};
   assign aSecondOut = {4'h0, timerChanOut[1], timerChanOut[0]};
   // Bit 2 is input-only as a port
   assign aDirEff = {portaDir[5:3], 1'b0, portaDir[1:0]};

   assign bFirst = {timerChanEn[3], timerChanEn[2], analogEn[9:4]};
   assign bSecond = {2'h0, asyncSerialEn, asyncSerialEn, syncSerialEn};
   assign bSecondOe = {2'h0, 1'b1, 1'b0, syncSerialOe};
   assign bSecondOut = {2'h0, asyncTxOut, 1'b0, syncSerialOut};

   wire [7:0] bFirstOe;
   wire [7:0] bFirstOut;
   assign bFirstOe = {timerChanOe[3], timerChanOe[2], 6'h00};
   assign bFirstOut = {timerChanOut[3], timerChanOut[2], 6'h00};

   genvar i;
   generate
      for (i = 0; i < `SPMUX_PA_PINS; i = i + 1) begin : gPa
         spmux_pin_arb uArb (
            .clk(clk),
            .rstSync_n(rstSync_q),
            .enFirst(aFirst[i]),
            .enSecond(aSecond[i]),
            .enThird(aThird[i]),
            .firstOe(aFirstOe[i]),
            .firstOut(aFirstOut[i]),
            .secondOe(aSecondOe[i]),
            .secondOut(aSecondOut[i]),
            .thirdOe(1'b0),
            .thirdOut(1'b0),
            .portDir(aDirEff[i]),
            .portOut(portaOut[i]),
            .owner(portaOwner[3*i+2:3*i]),
            .pinOe(portaPinOe[i]),
            .pinOut(portaPinOut[i])
         );
      end
      for (i = 0; i < `SPMUX_PORT_WIDTH; i = i + 1) begin : gPb
         spmux_pin_arb uArb (
            .clk(clk),
            .rstSync_n(rstSync_q),
            .enFirst(bFirst[i]),
            .enSecond(bSecond[i]),
            .enThird(1'b0),
            .firstOe(bFirstOe[i]),
            .firstOut(bFirstOut[i]),
            .secondOe(bSecondOe[i]),
            .secondOut(bSecondOut[i]),
            .thirdOe(1'b0),
            .thirdOut(1'b0),
            .portDir(portbDir[i]),
            .portOut(portbOut[i]),
            .owner(portbOwner[3*i+2:3*i]),
            .pinOe(portbPinOe[i]),
            .pinOut(portbPinOut[i])
         );
      end
   endgenerate

   // ==================================================
   // Inbound routing: enabled readers see the pin level unless masked as below.
   // Analog sampling is passive, so it never masks a lower module.
   // Key irqs and the timer ext clock read an inactive level when a non-analog owner outranks them.

   // Lower modules are masked only by non-analog owners
   wire [5:0] aBlockKey;
   wire [7:0] bBlockSer;
   assign aBlockKey = {oscInputEn, oscOutputEn, extResetEn,
      extIrqEn | timerExtClockEn, timerChanEn[1:0]};
   assign bBlockSer = {timerChanEn[3:2], 6'h00};

   always @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         portaIn <= 6'h00;
         portbIn <= 8'h00;
         analogIn <= 10'h000;
         timerChanIn <= 4'h0;
         timerExtClock <= 1'b0;
         keyIrqIn <= 6'h00;
         extIrqIn <= 1'b1;
         extReset_n <= 1'b1;
         oscInput <= 1'b0;
         syncSerialIn <= 4'h0;
         asyncRxIn <= 1'b1;
      end else begin
         portaIn <= paSync_q;
         portbIn <= pbSync_q;
         analogIn <= {pbSync_q[5:0], paSync_q[5:4], paSync_q[1:0]} & analogEn;
         timerChanIn <= {pbSync_q[7:6], paSync_q[1:0]} & timerChanEn;
         timerExtClock <= timerExtClockEn & ~extIrqEn & paSync_q[2];
         keyIrqIn <= paSync_q & keyIrqEn & ~aBlockKey;
         extIrqIn <= extIrqEn ? paSync_q[2] : 1'b1;
         extReset_n <= extResetEn ? paSync_q[3] : 1'b1;
         oscInput <= oscInputEn & paSync_q[5];
         syncSerialIn <= pbSync_q[3:0] & syncSerialEn & ~bBlockSer[3:0];
         asyncRxIn <= asyncSerialEn ? pbSync_q[4] : 1'b1;
      end
   end
endmodule

// ### shared/spmux_consts.vh
`ifndef SPMUX_CONSTS_VH
`define SPMUX_CONSTS_VH

// ==================================================
// Pin counts of each port
`define SPMUX_PORT_WIDTH 8
`define SPMUX_PA_PINS 6

// ==================================================
// Owner codes reported per pin (3 bits)
`define SPMUX_OWN_PORT 3'h0
`define SPMUX_OWN_KEY 3'h1
`define SPMUX_OWN_THIRD 3'h2
`define SPMUX_OWN_SECOND 3'h3
`define SPMUX_OWN_FIRST 3'h4

// ==================================================
// Reset values
`define SPMUX_RST_DIR 8'h00
`define SPMUX_RST_OWNED 1'b0

`endif

// ### verif/spmux_board.sv
`timescale 1ns/1ps
module spmux_board (
   input wire clk,
   input wire [13:0] pinOut,
   input wire [13:0] pinOe,
   output wire [13:0] pinIn
);
   logic [13:0] noise_q = 14'h2A5B;
   always @(posedge clk) noise_q <= {noise_q[12:0], noise_q[13] ^ noise_q[4]};
   // Undriven pins float: a moving pattern so stale levels never pass
   assign pinIn = (pinOut & pinOe) | (noise_q & ~pinOe);
endmodule

// ### verif/spmux_checker.sv
`timescale 1ns/1ps
// ====================
// Pin ownership checks
module spmux_checker (
   input wire clk,
   input wire rst_n,
   input wire [5:0] portaPinIn,
   input wire [5:0] portaPinOe,
   input wire [7:0] portbPinOe,
   input wire [9:0] analogEn,
   input wire [3:0] timerChanEn,
   input wire [3:0] timerChanOe,
   input wire [3:0] timerChanIn,
   input wire [5:0] keyIrqEn,
   input wire extIrqEn,
   input wire oscOutputEn,
   input wire oscInputEn,
   input wire [3:0] syncSerialEn,
   input wire asyncSerialEn,
   input wire [17:0] portaOwner,
   input wire [23:0] portbOwner
);
   logic [2:0] relCnt_q;
   // Margin past the internal release so owners are live
   wire live = relCnt_q > 3'h4;
   wire idle = portaOwner == 18'h0 && portbOwner == 24'h0 && portaPinOe == 6'h0
      && portbPinOe == 8'h0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) relCnt_q <= 3'h0;
      else if (relCnt_q != 3'h7) relCnt_q <= relCnt_q + 3'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!live);
   property p_rst_idle;
      $rose(live) |-> $past(idle, 2);
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("pins active after reset");
   property p_a0_first;
      analogEn[0] |=> portaOwner[2:0] == 3'h4 && !portaPinOe[0];
   endproperty
   a_a0_first: assert property (p_a0_first) else $error("A0 analog not owner");
   property p_a1_second;
      timerChanEn[1] && !analogEn[1] |=>
         portaOwner[5:3] == 3'h3 && portaPinOe[1] == $past(timerChanOe[1]);
   endproperty
   a_a1_second: assert property (p_a1_second) else $error("A1 timer not owner");
   property p_a2_first;
      extIrqEn |=> portaOwner[8:6] == 3'h4 && !portaPinOe[2];
   endproperty
   a_a2_first: assert property (p_a2_first) else $error("A2 irq not owner");
   property p_a4_first;
      oscOutputEn |=> portaOwner[14:12] == 3'h4 && portaPinOe[4];
   endproperty
   a_a4_first: assert property (p_a4_first) else $error("A4 osc not owner");
   property p_a5_key;
      keyIrqEn[5] && !oscInputEn && !analogEn[3] |=> portaOwner[17:15] == 3'h2;
   endproperty
   a_a5_key: assert property (p_a5_key) else $error("A5 key not owner");
   property p_b3_second;
      syncSerialEn[3] && !analogEn[7] |=> portbOwner[11:9] == 3'h3;
   endproperty
   a_b3_second: assert property (p_b3_second) else $error("B3 select not owner");
   property p_b5_second;
      asyncSerialEn && !analogEn[9] |=> portbOwner[17:15] == 3'h3 && portbPinOe[5];
   endproperty
   a_b5_second: assert property (p_b5_second) else $error("B5 tx not owner");
   property p_b7_timer;
      timerChanEn[3] |=> portbOwner[23:21] == 3'h4 && portbPinOe[7] == $past(timerChanOe[3]);
   endproperty
   a_b7_timer: assert property (p_b7_timer) else $error("B7 timer not owner");
   property p_a0_pass;
      (analogEn[0] && timerChanEn[0]) [*4] |-> timerChanIn[0] == $past(portaPinIn[0], 3);
   endproperty
   a_a0_pass: assert property (p_a0_pass) else $error("A0 timer input cut off");
endmodule

// ### verif/tb_shared_pin_priority_mux.sv
`timescale 1ns/1ps
module tb_shared_pin_priority_mux;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [75:0] s = 76'h0;
   wire [5:0] aOut, aOe;
   wire [7:0] bOut, bOe;
   wire [13:0] pinIn;
   wire [17:0] aOwn;
   wire [23:0] bOwn;
   wire [5:0] aIn, keyIn;
   wire [7:0] bIn;
   wire [9:0] anIn;
   wire [3:0] tIn, sIn;
   wire extClk, irqIn, rstIn_n, oscIn, rxIn;
   logic [13:0] pinQ[$];
   int err_count = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   spmux_top u_spmux_top (.clk(clk), .rst_n(rst_n), .portaPinIn(pinIn[5:0]),
      .portaPinOut(aOut), .portaPinOe(aOe), .portbPinIn(pinIn[13:6]), .portbPinOut(bOut),
      .portbPinOe(bOe), .portaDir(s[5:0]), .portaOut(s[11:6]), .portbDir(s[19:12]),
      .portbOut(s[27:20]), .portaIn(aIn), .portbIn(bIn), .analogEn(s[37:28]), .analogIn(anIn),
      .timerChanEn(s[41:38]), .timerChanOe(s[45:42]), .timerChanOut(s[49:46]),
      .timerChanIn(tIn), .timerExtClockEn(s[50]), .timerExtClock(extClk), .keyIrqEn(s[56:51]),
      .keyIrqIn(keyIn), .extIrqEn(s[57]), .extIrqIn(irqIn), .extResetEn(s[58]),
      .extReset_n(rstIn_n), .oscOutputEn(s[59]), .oscOutputVal(s[60]), .oscInputEn(s[61]),
      .oscInput(oscIn), .syncSerialEn(s[65:62]), .syncSerialOe(s[69:66]),
      .syncSerialOut(s[73:70]), .syncSerialIn(sIn), .asyncSerialEn(s[74]), .asyncTxOut(s[75]),
      .asyncRxIn(rxIn), .portaOwner(aOwn), .portbOwner(bOwn));
   spmux_board u_spmux_board (.clk(clk), .pinOut({bOut, aOut}), .pinOe({bOe, aOe}),
      .pinIn(pinIn));
   // Pin levels as the design sampled them, newest first
   always @(posedge clk) begin
      pinQ.push_front(pinIn);
      if (pinQ.size() > 4) void'(pinQ.pop_back());
   end
   // ====================
   // Reference model: {owner, oe, out} per pin, first-ranked enable wins
   function automatic logic [4:0] arb(input logic [2:0] en, input logic [2:0] oe,
      input logic [2:0] dat, input logic dir, input logic pout);
      if (en[2]) return {3'h4, oe[2], dat[2]};
      if (en[1]) return {3'h3, oe[1], dat[1]};
      if (en[0]) return {3'h2, oe[0], dat[0]};
      return {3'h0, dir, pout};
   endfunction
   function automatic logic [13:0][4:0] model(input logic [75:0] v);
      logic [13:0][4:0] m;
      m[0] = arb({v[28], v[38], v[51]}, {1'b0, v[42], 1'b0}, {1'b0, v[46], 1'b0}, v[0], v[6]);
      m[1] = arb({v[29], v[39], v[52]}, {1'b0, v[43], 1'b0}, {1'b0, v[47], 1'b0}, v[1], v[7]);
      m[2] = arb({v[57], v[50], v[53]}, 3'h0, 3'h0, 1'b0, v[8]);
      m[3] = arb({v[58], v[54], 1'b0}, 3'h0, 3'h0, v[3], v[9]);
      m[4] = arb({v[59], v[30], v[55]}, 3'h4, {v[60], 2'h0}, v[4], v[10]);
      m[5] = arb({v[61], v[31], v[56]}, 3'h0, 3'h0, v[5], v[11]);
      for (int i = 0; i < 4; i++)
         m[6 + i] = arb({v[32 + i], v[62 + i], 1'b0}, {1'b0, v[66 + i], 1'b0},
            {1'b0, v[70 + i], 1'b0}, v[12 + i], v[20 + i]);
      m[10] = arb({v[36], v[74], 1'b0}, 3'h0, 3'h0, v[16], v[24]);
      m[11] = arb({v[37], v[74], 1'b0}, 3'h2, {1'b0, v[75], 1'b0}, v[17], v[25]);
      for (int k = 0; k < 2; k++)
         m[12 + k] = arb({v[40 + k], 2'h0}, {v[44 + k], 2'h0}, {v[48 + k], 2'h0}, v[18 + k],
            v[26 + k]);
      return m;
   endfunction
   function automatic logic [75:0] rnd();
      return 76'({$urandom, $urandom, $urandom});
   endfunction
   task automatic cmp(input string name, input logic [9:0] exp, input logic [9:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask
   // Inbound outputs reflect the pin two edges before the last one
   task automatic chk(input logic inRst);
      logic [13:0][4:0] m;
      logic [13:0] p;
      logic [3:0] got;
      m = inRst ? '0 : model(s);
      p = pinQ[2];
      for (int i = 0; i < 14; i++) begin
         got = i < 6 ? {aOwn[3 * i +: 3], aOe[i]} : {bOwn[3 * (i - 6) +: 3], bOe[i - 6]};
         n_checks++;
         if (got !== m[i][4:1]) begin
            $display("ERROR pin %0d owner/oe expected %h seen %h", i, m[i][4:1], got);
            err_count++;
         end
         if (!inRst && m[i][1])
            cmp($sformatf("pin %0d out", i), {9'h0, m[i][0]},
               {9'h0, (i < 6 ? aOut[i] : bOut[i - 6])});
      end
      if (!inRst) begin
         cmp("port a in", {4'h0, p[5:0]}, {4'h0, aIn});
         cmp("port b in", {2'h0, p[13:6]}, {2'h0, bIn});
         cmp("analog in", {p[11:6], p[5:4], p[1:0]} & s[37:28], anIn);
         cmp("timer in", {6'h0, {p[13:12], p[1:0]} & s[41:38]}, {6'h0, tIn});
         cmp("ext clock", {9'h0, s[50] & ~s[57] & p[2]}, {9'h0, extClk});
         cmp("key in", {4'h0, p[5:0] & s[56:51] & ~{s[61], s[59], s[58], s[57] | s[50],
            s[39:38]}}, {4'h0, keyIn});
         cmp("irq in", {9'h0, (s[57] ? p[2] : 1'b1)}, {9'h0, irqIn});
         cmp("reset in", {9'h0, (s[58] ? p[3] : 1'b1)}, {9'h0, rstIn_n});
         cmp("osc in", {9'h0, s[61] & p[5]}, {9'h0, oscIn});
         cmp("sync in", {6'h0, p[9:6] & s[65:62]}, {6'h0, sIn});
         cmp("rx in", {9'h0, (s[74] ? p[10] : 1'b1)}, {9'h0, rxIn});
      end
   endtask
   task automatic results();
      if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hEF4F));
      @(posedge clk) s <= rnd();
      repeat (15) @(posedge clk);
      @(negedge clk) chk(1'b1);
      @(posedge clk) rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      for (int n = 0; n < 400; n++) begin
         @(posedge clk) s <= n[0] ? rnd() : rnd() & rnd();
         @(posedge clk);
         @(negedge clk) chk(1'b0);
         if (n == 200) begin
            @(posedge clk) rst_n <= 1'b0;
            repeat (3) @(posedge clk);
            @(negedge clk) chk(1'b1);
            @(posedge clk) rst_n <= 1'b1;
            repeat (6) @(posedge clk);
         end
      end
      @(posedge clk) s <= (76'h1 << 28) | (76'h1 << 38);
      repeat (8) @(posedge clk);
      @(negedge clk) chk(1'b0);
      @(posedge clk) s <= 76'h1 << 30;
      @(posedge clk);
      @(negedge clk) chk(1'b0);
      results();
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      results();
   end
endmodule
bind spmux_top spmux_checker u_spmux_checker (.*);
